// file: shared/bvil_pkg.sv
// Shared constants for the bus vectored interrupt logic
package bvil_pkg;
  // ------------------------------------------------------------------
  // Line counts and widths
  // ------------------------------------------------------------------
  localparam int NUM_IRQ      = 8;   // Shared request lines
  localparam int CODE_W       = 3;   // Interrupt code width on address
  localparam int ADDR_W       = 16;  // Address lines carried in interface
  localparam int DATA_W       = 16;  // Data lines carried in interface
  localparam int BYTE_W       = 8;   // Low data lines width
  localparam int VEC_W        = 16;  // Full vector width (two bytes)
  localparam int CODE_LSB     = 0;   // Code sits in low address bits
  // ------------------------------------------------------------------
  // Timing counts (core_clk cycles)
  // ------------------------------------------------------------------
  localparam int CLK_NS       = 100; // Core clock period in ns
  localparam int ACK_LEN_NS   = 600; // Strobe time, covers both syncs
  localparam int ACK_LEN_CYC  = (ACK_LEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS       = 100; // Idle time between acknowledges
  localparam int GAP_CYC      = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;   // Width of cycle counters
  // Reset values
  localparam logic [VEC_W-1:0] VEC_RST = 16'h0000;
endpackage : bvil_pkg

// file: shared/bvil_bus_if.sv
// Interface joining interrupting slave and bus master
`timescale 1ns/1ps
interface bvil_bus_if;
  import bvil_pkg::*;
  // Open-collector request lines: per-driver pull enables
  logic [NUM_IRQ-1:0] slvReqOe;   // Slave pulls line active
  logic [NUM_IRQ-1:0] irqRequestLines; // Wired level, 1 = active
  // Acknowledge strobe and lock, master driven, 1 = active
  logic               irqAckStrobe;
  logic               busLock;
  // Address lines from master
  logic [ADDR_W-1:0]  adrOut;
  logic               adrOe;
  // Data lines from slave (three-state)
  logic [DATA_W-1:0]  slvDatOut;
  logic               slvDatOe;
  logic [DATA_W-1:0]  datLines;   // Resolved data
  // Wired-OR resolution of open-collector lines
  assign irqRequestLines = slvReqOe;
  assign datLines = slvDatOe ? slvDatOut : '0;
  modport slave
  (
    input  irqRequestLines, irqAckStrobe, busLock, adrOut, adrOe,
    output slvReqOe, slvDatOut, slvDatOe
  );
  modport master
  (
    input  irqRequestLines, datLines,
    output irqAckStrobe, busLock, adrOut, adrOe
  );
endinterface : bvil_bus_if

// file: logic/bvil_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module bvil_sync
  import bvil_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_r;     // First stage, read only by second stage
  logic [W-1:0] stable_r;   // Second stage

  // Two stages; reset takes zero
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta_r   <= '0;
      stable_r <= '0;
    end
    else
    begin
      meta_r   <= asyncIn;
      stable_r <= meta_r;
    end
  end
  assign syncOut = stable_r;
endmodule // bvil_sync

// file: logic/bvil_slave.sv
// Interrupting slave end: request line drive and vector return
`timescale 1ns/1ps
module bvil_slave
  import bvil_pkg::*;
#(
  parameter int unsigned LINE = 0   // Request line this slave drives
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Bus side
  bvil_bus_if.slave               bus,
  // User side
  input  wire logic               srcPending,  // Service needs interrupt
  input  wire logic [VEC_W-1:0]   vector,      // Vector to return
  input  wire logic               threeAck,    // 1 = three-ack variant
  output logic                    selected,    // Slave chosen by code
  output logic                    vecDone      // Vector fully returned
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              reqOe;     // Pulling request line
    logic [DATA_W-1:0] dat;       // Data driven
    logic              datOe;     // Data drivers enabled
    logic [1:0]        ackCnt;    // Acks seen in sequence
    logic              ackPrev;   // Last synced strobe
    logic              sel;       // Code matched
    logic              done;      // Sequence done pulse
  } bvils_st_s;
  bvils_st_s st_r, st_nxt;

  logic       ackS;               // Synced strobe
  logic       lockS;              // Synced lock
  logic [ADDR_W-1:0] adrS;        // Synced address

  bvil_sync #(.W(2 + ADDR_W)) bvil_sync_inst
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .asyncIn  ({bus.irqAckStrobe, bus.busLock,
                bus.adrOe ? bus.adrOut : {ADDR_W{1'b0}}}),
    .syncOut  ({ackS, lockS, adrS})
  );

  // Next-state logic
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    // Level request held until source clears it
    st_nxt.reqOe = srcPending;                      // RULE_01 RULE_02 RULE_17
    if (ackS && !st_r.ackPrev)
    begin
      // Leading edge: address valid, count ack
      if (st_r.ackCnt != 2'd3)
        st_nxt.ackCnt = st_r.ackCnt + 2'd1;
      if (st_r.ackCnt == 2'd1)
        // Code from master selects this slave
        st_nxt.sel = st_r.reqOe &&
          (adrS[CODE_W-1:0] == CODE_W'(LINE));      // RULE_16 RULE_11
      if (st_r.sel || (st_r.ackCnt == 2'd1 && st_r.reqOe &&
          adrS[CODE_W-1:0] == CODE_W'(LINE)))
      begin
        st_nxt.datOe = 1'b1;                        // RULE_05
        // Byte on low lines; low byte first in three-ack case
        if (threeAck && st_r.ackCnt == 2'd2)
          st_nxt.dat = {8'h00, vector[VEC_W-1:BYTE_W]}; // RULE_13 RULE_15
        else
          st_nxt.dat = {8'h00, vector[BYTE_W-1:0]}; // RULE_12 RULE_15
      end
    end
    else if (!ackS && st_r.ackPrev)
    begin
      // Trailing edge: release data drivers
      st_nxt.datOe = 1'b0;                          // RULE_17
      st_nxt.dat   = '0;
      if (st_r.sel && ((threeAck && st_r.ackCnt == 2'd3) ||
          (!threeAck && st_r.ackCnt == 2'd2)))
        st_nxt.done = 1'b1;                         // RULE_14
    end
    // Sequence ends when lock drops with strobe idle
    if (!lockS && !ackS)
    begin
      st_nxt.ackCnt = '0;                           // RULE_09
      st_nxt.sel    = 1'b0;
    end
    st_nxt.ackPrev = ackS;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb
  begin
    bus.slvReqOe       = '0;
    bus.slvReqOe[LINE] = st_r.reqOe;
  end
  assign bus.slvDatOut = st_r.dat;
  assign bus.slvDatOe  = st_r.datOe;
  assign selected      = st_r.sel;
  assign vecDone       = st_r.done;
endmodule // bvil_slave

// file: logic/bvil_master.sv
// Bus master end: priority, acknowledge sequence, vector capture
// ----------------------------------------------------------------------
// Functional notes
// RULE_01: Slave pulls one of eight open-collector lines
// RULE_02: Requests are level sensitive, no edges
// RULE_03: Line zero highest priority, falling with index
// RULE_04: Only master drives acknowledge strobe
// RULE_05: Address valid at lead, data by trail
// RULE_06: Local scheme builds vector inside master
// RULE_07: Local scheme handles any active line
// RULE_08: Bus scheme interrupts processor, then acknowledges
// RULE_09: First acknowledge freezes priority state
// RULE_10: Master holds bus lock across sequence
// RULE_11: Code on address is winning line index
// RULE_12: Two-ack variant: one vector byte returned
// RULE_13: Three-ack variant: two bytes, one each
// RULE_14: One bus variant per system; schemes coexist
// RULE_15: Bytes on low data lines, LSB line zero
// RULE_16: Slave answers only on matching code
// RULE_17: Slave releases data at strobe end
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module bvil_master
  import bvil_pkg::*;
#(
  parameter int unsigned ACK_CYC = ACK_LEN_CYC,  // Strobe length
  parameter int unsigned GAP     = GAP_CYC,      // Gap between strobes
  parameter logic [VEC_W-1:0] LOCAL_BASE = 16'h0040 // Local vector base
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // Bus side
  bvil_bus_if.master              bus,
  // Configuration
  input  wire logic [NUM_IRQ-1:0] busVecMask,    // 1 = line bus vectored
  input  wire logic               threeAck,      // Three-ack variant
  // Processor side
  input  wire logic               cpuAck,        // Processor takes irq
  output logic                    cpuIrq,        // Interrupt to processor
  output logic [VEC_W-1:0]        cpuVector,     // Vector for processor
  output logic                    vecValid       // One-cycle pulse
);
  // ------------------------------------------------------------------
  // Types and helpers
  // ------------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,  // Waiting for a request
    S_IRQ   = 6'b000010,  // Processor interrupted
    S_ACK   = 6'b000100,  // Strobe active
    S_GAP   = 6'b001000,  // Between strobes, lock held
    S_DONE  = 6'b010000,  // Deliver vector
    S_LOCAL = 6'b100000   // Local vector delivery
  } bvilm_state_e;

  typedef struct packed {
    bvilm_state_e       state;
    logic [CNT_W-1:0]   cnt;      // Cycle counter
    logic [1:0]         ackNum;   // Acks issued
    logic [CODE_W-1:0]  code;     // Frozen winning code
    logic [VEC_W-1:0]   vec;      // Captured vector
    logic               ack;      // Strobe
    logic               lock;     // Bus lock
    logic               adrOe;    // Address driven
    logic               irq;      // To processor
    logic               valid;    // Vector pulse
  } bvilm_st_s;
  bvilm_st_s st_r, st_nxt;

  // Highest-priority active line: lowest index wins
  function automatic logic [CODE_W-1:0] prio_enc(
    input logic [NUM_IRQ-1:0] req);
    logic [CODE_W-1:0] idx;
    idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
      if (req[i])
        idx = CODE_W'(i);
    return idx;
  endfunction

  logic [NUM_IRQ-1:0] reqS;       // Synced request lines
  logic [DATA_W-1:0]  datS;       // Synced data
  logic [CODE_W-1:0]  winner;     // Live winner

  bvil_sync #(.W(NUM_IRQ + DATA_W)) bvil_sync_inst
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .asyncIn  ({bus.irqRequestLines, bus.datLines}),
    .syncOut  ({reqS, datS})
  );

  assign winner = prio_enc(reqS);                   // RULE_03

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Data is sampled at the strobe's trailing edge; the slave's answer
  // needs five cycles through both synchronisers, so ACK_CYC must be
  // at least six or the capture sees idle data lines.
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.valid = 1'b0;
    case (st_r.state)
      S_IDLE:
      begin
        if (|reqS)                                  // RULE_02
        begin
          st_nxt.code = winner;
          if (busVecMask[winner])
          begin
            st_nxt.irq   = 1'b1;                    // RULE_08
            st_nxt.state = S_IRQ;
          end
          else
            st_nxt.state = S_LOCAL;                 // RULE_07
        end
      end
      S_LOCAL:
      begin
        // Vector built locally, no bus transfer
        st_nxt.vec   = LOCAL_BASE | VEC_W'(st_r.code); // RULE_06
        st_nxt.valid = 1'b1;
        st_nxt.state = S_DONE;
      end
      S_IRQ:
      begin
        if (cpuAck)
        begin
          st_nxt.irq    = 1'b0;
          st_nxt.lock   = 1'b1;                     // RULE_10
          st_nxt.ack    = 1'b1;                     // RULE_04
          st_nxt.ackNum = 2'd1;
          st_nxt.cnt    = '0;
          st_nxt.code   = winner;                   // RULE_09
          st_nxt.state  = S_ACK;
        end
      end
      S_ACK:
      begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.cnt == CNT_W'(ACK_CYC - 1))
        begin
          // Trailing edge: data present now
          st_nxt.ack = 1'b0;                        // RULE_05
          st_nxt.cnt = '0;
          // High byte cleared so a one-byte vector leaves no stale data
          if (st_r.ackNum == 2'd2)
            st_nxt.vec = {{(VEC_W-BYTE_W){1'b0}},
                          datS[BYTE_W-1:0]};        // RULE_15
          if (st_r.ackNum == 2'd3)
            st_nxt.vec[VEC_W-1:BYTE_W] = datS[BYTE_W-1:0]; // RULE_13
          // After first ack drive frozen code
          st_nxt.adrOe = 1'b1;                      // RULE_11
          if ((threeAck && st_r.ackNum == 2'd3) ||
              (!threeAck && st_r.ackNum == 2'd2))   // RULE_12 RULE_14
          begin
            st_nxt.lock  = 1'b0;
            st_nxt.adrOe = 1'b0;
            st_nxt.valid = 1'b1;
            st_nxt.state = S_DONE;
          end
          else
            st_nxt.state = S_GAP;
        end
      end
      S_GAP:
      begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
        if (st_r.cnt == CNT_W'(GAP - 1))
        begin
          st_nxt.cnt    = '0;
          st_nxt.ack    = 1'b1;                     // RULE_10
          st_nxt.ackNum = st_r.ackNum + 2'd1;
          st_nxt.state  = S_ACK;
        end
      end
      S_DONE:
      begin
        // Wait for the processor's service to drop the line
        if (!reqS[st_r.code])
          st_nxt.state = S_IDLE;
      end
      default:
        st_nxt = '{state: S_IDLE, default: '0};
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      st_r       <= '0;
      st_r.state <= S_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign bus.irqAckStrobe = st_r.ack;
  assign bus.busLock      = st_r.lock;
  assign bus.adrOe        = st_r.adrOe;
  assign bus.adrOut       = ADDR_W'(st_r.code);
  assign cpuIrq           = st_r.irq;
  assign cpuVector        = st_r.vec;
  assign vecValid         = st_r.valid;
endmodule // bvil_master

// file: tb/bvil_monitor.sv
// Checker for the bus between master and slave ends
`timescale 1ns/1ps
module bvil_monitor
  import bvil_pkg::*;
#(
  parameter int unsigned LINE    = 0,  // Line the slave drives
  parameter int unsigned ACK_CYC = ACK_LEN_CYC // Strobe length, cycles
)
(
  // Clock and reset
  input logic                core_clk,
  input logic                rst_b,
  // Request lines
  input logic [NUM_IRQ-1:0]  slvReqOe,
  input logic [NUM_IRQ-1:0]  irqRequestLines,
  // Master side
  input logic                irqAckStrobe,
  input logic                busLock,
  input logic [ADDR_W-1:0]   adrOut,
  input logic                adrOe,
  // Slave data
  input logic [DATA_W-1:0]   slvDatOut,
  input logic                slvDatOe,
  input logic [DATA_W-1:0]   datLines
);
  // ------------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------------
  logic [CNT_W-1:0] ackLen_r;  // Cycles the strobe has been high

  // Counts strobe length; a repetition cannot take a parameter
  always_ff @(posedge core_clk)
    if (!rst_b)
      ackLen_r <= '0;
    else if (irqAckStrobe)
      ackLen_r <= ackLen_r + 1'b1;
    else
      ackLen_r <= '0;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  chk_strobe_len: assert property
    ($fell(irqAckStrobe) |-> ackLen_r == CNT_W'(ACK_CYC))
    else $error("Acknowledge strobe length wrong");
  chk_lock_held: assert property
    (irqAckStrobe |-> busLock)
    else $error("Strobe seen without bus lock");
  chk_strobe_gap: assert property
    ($fell(irqAckStrobe) && busLock |-> ##1 irqAckStrobe)
    else $error("Strobes not back to back");
  chk_lock_end: assert property
    ($fell(busLock) |-> $fell(irqAckStrobe))
    else $error("Lock dropped away from last strobe");
  chk_code_match: assert property
    (slvDatOe |-> adrOut[CODE_W-1:0] == CODE_W'(LINE))
    else $error("Slave drove data without code match");
  chk_code_driven: assert property
    ($rose(slvDatOe) |-> adrOe)
    else $error("Slave drove data with no code on address");
  chk_low_byte: assert property
    (slvDatOe |-> slvDatOut[15:8] == 8'h00)
    else $error("Vector byte not on low data lines");
  chk_data_release: assert property
    ($fell(irqAckStrobe) |-> ##[1:5] !slvDatOe)
    else $error("Slave held data after strobe");
  chk_addr_stable: assert property
    (adrOe && $past(adrOe) |-> $stable(adrOut))
    else $error("Interrupt code changed in sequence");
  chk_req_line: assert property
    ((slvReqOe & ~(8'h01 << LINE)) == 8'h00)
    else $error("Slave pulled a foreign request line");
  chk_addr_first: assert property
    ($rose(adrOe) |-> busLock && !irqAckStrobe)
    else $error("Code driven outside first gap");
endmodule // bvil_monitor

// file: tb/bvil_tb_top.sv
// Bench top: master and slave joined, driven from user sides
`timescale 1ns/1ps
module bvil_tb_top;
  import bvil_pkg::*;
  localparam int unsigned SLV_LINE = 2;  // Line under test
  localparam int unsigned ACK_T    = 6;  // Long enough for capture
  localparam logic [15:0] LOC_BASE = 16'h0040; // Local vector base
  // Clock and reset
  logic               core_clk;
  logic               rst_b;
  // Master user side
  logic [NUM_IRQ-1:0] busVecMask;
  logic               threeAck;
  logic               cpuAck;
  logic               cpuIrq;
  logic [VEC_W-1:0]   cpuVector;
  logic               vecValid;
  // Slave user side
  logic               srcPending;
  logic [VEC_W-1:0]   vector;
  logic               selected;
  logic               vecDone;
  // Result counters
  int                 miscompares;
  int                 numChecks;

  bvil_bus_if bus ();
  bvil_master #(.ACK_CYC(ACK_T), .GAP(1), .LOCAL_BASE(LOC_BASE))
    bvil_master_inst (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .busVecMask(busVecMask), .threeAck(threeAck), .cpuAck(cpuAck),
    .cpuIrq(cpuIrq), .cpuVector(cpuVector), .vecValid(vecValid));
  bvil_slave #(.LINE(SLV_LINE)) bvil_slave_inst (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus),
    .srcPending(srcPending), .vector(vector), .threeAck(threeAck),
    .selected(selected), .vecDone(vecDone));
  bvil_monitor #(.LINE(SLV_LINE), .ACK_CYC(ACK_T)) bvil_monitor_inst (
    .core_clk(core_clk), .rst_b(rst_b), .slvReqOe(bus.slvReqOe),
    .irqRequestLines(bus.irqRequestLines),
    .irqAckStrobe(bus.irqAckStrobe), .busLock(bus.busLock),
    .adrOut(bus.adrOut), .adrOe(bus.adrOe), .slvDatOut(bus.slvDatOut),
    .slvDatOe(bus.slvDatOe), .datLines(bus.datLines));

  // 100 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One interrupt from request to release, watching the bus
  task automatic run_seq(input logic thr, input logic [7:0] msk,
                         input logic [15:0] vec);
    logic busMode;
    logic sel;
    logic done;
    logic prevAck;
    logic gotVec;
    int   n;
    int   acks;
    busMode = msk[SLV_LINE];
    sel = 1'b0;
    done = 1'b0;
    prevAck = 1'b0;
    gotVec = 1'b0;
    acks = 0;
    threeAck = thr;
    busVecMask = msk;
    vector = vec;
    srcPending = 1'b1;
    if (busMode)
    begin
      n = 0;
      while (cpuIrq !== 1'b1 && n < 50)
      begin
        @(negedge core_clk);
        n++;
      end
      if (n >= 50)
      begin
        miscompares++;
        finish_test();
      end
      check({15'h0000, cpuIrq}, 16'h0001);
      // Idle bus while only the processor is told
      check({15'h0000, bus.irqAckStrobe}, 16'h0000);
      cpuAck = 1'b1;
      @(negedge core_clk);
      cpuAck = 1'b0;
    end
    n = 0;
    while (n < 300 && (!gotVec || n < 20))
    begin
      @(negedge core_clk);
      n++;
      if (bus.irqAckStrobe === 1'b1 && !prevAck)
        acks++;
      prevAck = (bus.irqAckStrobe === 1'b1);
      if (selected === 1'b1)
        sel = 1'b1;
      if (vecDone === 1'b1)
        done = 1'b1;
      if (vecValid === 1'b1)
      begin
        gotVec = 1'b1;
        if (busMode)
          check(cpuVector, thr ? vec : {8'h00, vec[7:0]});
        else
          check(cpuVector, LOC_BASE | 16'(SLV_LINE));
      end
    end
    if (n >= 300)
    begin
      miscompares++;
      finish_test();
    end
    // Line still held: request is a level
    check({8'h00, bus.irqRequestLines}, 16'h0004);
    // Frozen code names the only active line
    if (busMode)
      check({13'h0000, bus.adrOut[2:0]}, 16'(SLV_LINE));
    repeat (12)
    begin
      @(negedge core_clk);
      if (vecDone === 1'b1)
        done = 1'b1;
    end
    check(16'(acks), busMode ? (thr ? 16'h0003 : 16'h0002) : 16'h0000);
    check({15'h0000, sel}, {15'h0000, busMode});
    check({15'h0000, done}, {15'h0000, busMode});
    srcPending = 1'b0;
    repeat (12) @(negedge core_clk);
    check({8'h00, bus.irqRequestLines}, 16'h0000);
  endtask

  // Main sequence
  initial
  begin
    miscompares = 0;
    numChecks = 0;
    rst_b = 1'b0;
    busVecMask = 8'hFF;
    threeAck = 1'b0;
    cpuAck = 1'b0;
    srcPending = 1'b0;
    vector = 16'h0000;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    run_seq(1'b0, 8'hFF, 16'hA5C3);
    run_seq(1'b1, 8'hFF, 16'h5A3C);
    run_seq(1'b0, 8'hFB, 16'h1111);
    run_seq(1'b1, 8'h04, 16'h8001);
    run_seq(1'b0, 8'h04, 16'h0077);
    // Second reset in mid-run, then a fresh sequence
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    check(cpuVector, 16'h0000);
    run_seq(1'b0, 8'h04, 16'h00FF);
    finish_test();
  end
endmodule // bvil_tb_top
